//--- qpot_pkg.sv
// Shared constants, types and helpers of the quad potentiometer serial slave
package qpot_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned CLK_PER_US       = CLK_HZ / 1_000_000;
  // Cycles lost between the STOP on the pins and the rise of NV_BUSY
  localparam int unsigned STOP_SYNC_LAG    = 4;
  localparam int unsigned NV_WRITE_TIME_US = 5000;
  localparam int unsigned NV_WRITE_CYCLES  =
    NV_WRITE_TIME_US * CLK_PER_US - STOP_SYNC_LAG;
  localparam int unsigned WIPER_SETTLE_US  = 10;
  localparam int unsigned WIPER_SETTLE_CYC = WIPER_SETTLE_US * CLK_PER_US;

  // Arbitrary value, fixed upper nibble of the slave address byte
  localparam logic [3:0] DEV_TYPE      = 4'hA;
  localparam logic [7:0] NV_RESET_VAL  = 8'h80;
  localparam logic [7:0] WIPER_MAX     = 8'hFF;
  localparam logic [7:0] WIPER_MIN     = 8'h00;
  localparam logic [1:0] SLOT_ZERO     = 2'h0;
  localparam logic [1:0] POT_LAST      = 2'h3;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;
  localparam int         OPC_LSB       = 4;
  localparam int         SLOT_LSB      = 2;
  localparam int         POT_LSB       = 0;

  typedef enum logic [3:0] {
    OP_GXFR_D2W = 4'h1,
    OP_INCDEC   = 4'h2,
    OP_GXFR_W2D = 4'h8,
    OP_RD_WIP   = 4'h9,
    OP_WR_WIP   = 4'hA,
    OP_RD_NV    = 4'hB,
    OP_WR_NV    = 4'hC,
    OP_XFR_D2W  = 4'hD,
    OP_XFR_W2D  = 4'hE
  } opcode_t;

  typedef enum logic [2:0] {
    PH_ADDR  = 3'h0,
    PH_INSTR = 3'h1,
    PH_DATA  = 3'h2,
    PH_READ  = 3'h3,
    PH_STEP  = 3'h4,
    PH_IDLE  = 3'h5
  } phase_t;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'h0,
    SQ_FETCH = 3'h1,
    SQ_LOAD  = 3'h2,
    SQ_PROG  = 3'h3,
    SQ_WAIT  = 3'h4
  } seq_t;

  function automatic logic op_valid(logic [3:0] op);
    case (op)
      OP_GXFR_D2W, OP_INCDEC, OP_GXFR_W2D, OP_RD_WIP, OP_WR_WIP,
      OP_RD_NV, OP_WR_NV, OP_XFR_D2W, OP_XFR_W2D: op_valid = 1'b1;
      default: op_valid = 1'b0;
    endcase
  endfunction : op_valid

  function automatic logic op_reads(logic [3:0] op);
    op_reads = (op == OP_RD_WIP) || (op == OP_RD_NV);
  endfunction : op_reads

  function automatic logic op_writes(logic [3:0] op);
    op_writes = (op == OP_WR_WIP) || (op == OP_WR_NV);
  endfunction : op_writes
endpackage : qpot_pkg

//--- nvm_if.sv
// Port of the setting store between sequencer and memory
`timescale 1ns/1ps
interface nvm_if #(
  parameter int AW = 4,
  parameter int DW = 8
);
  logic [AW-1:0] addr;
  logic          we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport host (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface : nvm_if

//--- nv_store.sv
// Nonvolatile setting slots, one byte per pot and slot
`timescale 1ns/1ps
module nv_store
  import qpot_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int DW    = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  nvm_if.mem        bus
);
  logic [DW-1:0] cell_q [DEPTH];
  logic [DW-1:0] rdata_q;

  // Reset stands in for the factory content of the cells
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        cell_q[i] <= DW'(NV_RESET_VAL);
      end
    end else if (bus.we) begin
      cell_q[bus.addr] <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= cell_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule : nv_store

//--- tap_decoder.sv
// One-hot tap switch select from a wiper position
`timescale 1ns/1ps
module tap_decoder #(
  parameter int W = 8,
  parameter int N = 256
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pos,
  output logic      [N-1:0] onehot
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      onehot <= N'(1);
    end else begin
      onehot <= N'(1) << pos;
    end
  end
endmodule : tap_decoder

//--- qpot_serial_slave.sv
// Two-wire slave front end and wiper sequencer of the quad potentiometer
// How it works
// - Wiper follows new instruction within bound
// - Wiper takes power-up position promptly
// - Nonvolatile write ends within write cycle
// - Busy writing: bus ignored, SDA released
// - SDA change while SCL high frames
// - Silent until a START is seen
// - Address low nibble must match straps
// - Receiver pulls SDA low on ninth clock
// - Write mode acknowledges matching address, valid opcode and unprotected data bytes
// - Read sends eight bits, continues on acknowledge
// - Instruction: opcode, slot bits, pot bits
// - Low two bits pick the wiper
// - Slot bits pick slot zero to three
// - Data register write programs at STOP
// - No acknowledge while busy, polling allowed
// - Write protect withholds data ack, skips programming
// - Protect after START blocks; during cycle not
// - Wiper position closes exactly one tap
// - Power-up loads wipers from slot zero
// - Step mode moves wiper per SCL pulse
`timescale 1ns/1ps
module qpot_serial_slave
  import qpot_pkg::*;
#(
  parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES,
  parameter int          NPOT      = 4,
  parameter int          WW        = 8
) (
  input  wire logic                     CLK,
  input  wire logic                     NRST,
  input  wire logic                     SCL,
  input  wire logic                     SDA_I,
  output logic                          SDA_O,
  output logic                          SDA_OE,
  input  wire logic [3:0]               ADDR_STRAP_PINS,
  input  wire logic                     WP_N,
  output logic [NPOT-1:0][WW-1:0]       WIPER_POS,
  output logic [NPOT-1:0][(1<<WW)-1:0]  TAP_SEL,
  output logic                          NV_BUSY
);
  localparam int CW = $clog2(NV_CYCLES + 1);

  // System clock side: pin synchronisers, frame tracking
  logic [2:0]          scl_s_q;
  logic [2:0]          sda_s_q;
  logic [3:0]          strap_m_q;
  logic [3:0]          strap_q;
  logic [1:0]          wp_s_q;
  logic                start_det;
  logic                stop_det;
  logic                in_frame_q;
  logic                link_clr_q;
  logic                wp_block_q;
  logic                busy;

  // Link side, clocked by SCL
  phase_t              ph_q;
  logic [3:0]          bit_q;
  logic [7:0]          sh_q;
  logic [7:0]          byte_in;
  logic                ack_q;
  logic                ack_d;
  logic                sda_oe_q;
  logic                sda_o_q;
  logic [1:0]          wpb_s_q;
  logic [3:0]          opcode_bits_q;
  logic [1:0]          slot_sel_q;
  logic [1:0]          pot_sel_q;
  logic [7:0]          data_q;
  logic                step_up_q;
  logic                ins_tog_q;
  logic                dat_tog_q;
  logic                stp_tog_q;

  // Event crossings into the system clock
  logic [2:0]          ins_s_q;
  logic [2:0]          dat_s_q;
  logic [2:0]          stp_s_q;
  logic                ins_ev;
  logic                dat_ev;
  logic                stp_ev;

  // Sequencer
  seq_t                seq_q;
  logic [1:0]          idx_q;
  logic [1:0]          slot_q;
  logic                gang_q;
  logic                to_rd_q;
  logic [CW-1:0]       wait_q;
  logic [NPOT-1:0][WW-1:0] wiper_position_reg_q;
  logic [7:0]          rd_data_q;
  logic                pend_q;
  logic                pend_gang_q;
  logic                pend_wiper_q;
  logic [1:0]          pend_pot_q;
  logic [1:0]          pend_slot_q;
  logic [7:0]          pend_data_q;
  logic                busy_q;

  nvm_if #(.AW(4), .DW(8)) nvm ();

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scl_s_q   <= 3'h7;
      sda_s_q   <= 3'h7;
      strap_m_q <= 4'h0;
      strap_q   <= 4'h0;
      wp_s_q    <= 2'h3;
    end else begin
      scl_s_q   <= {scl_s_q[1:0], SCL};
      sda_s_q   <= {sda_s_q[1:0], SDA_I};
      strap_m_q <= ADDR_STRAP_PINS;
      strap_q   <= strap_m_q;
      wp_s_q    <= {wp_s_q[0], WP_N};
    end
  end

  assign start_det = scl_s_q[1] & scl_s_q[2] & sda_s_q[2] & ~sda_s_q[1];
  assign stop_det  = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[2] & sda_s_q[1];
  assign busy      = (seq_q == SQ_PROG) || (seq_q == SQ_WAIT);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      in_frame_q <= 1'b0;
    end else if (start_det) begin
      in_frame_q <= 1'b1;
    end else if (stop_det) begin
      in_frame_q <= 1'b0;
    end
  end

  // Held clear outside frames and while busy; pulsed on repeated START
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      link_clr_q <= 1'b1;
    end else begin
      link_clr_q <= start_det | stop_det | ~in_frame_q | busy;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wp_block_q <= 1'b0;
    end else if (start_det) begin
      wp_block_q <= ~wp_s_q[1];
    end else if (in_frame_q && !wp_s_q[1]) begin
      wp_block_q <= 1'b1;
    end
  end

  // Link: bit counting, byte phases, acknowledge decision
  assign byte_in = {sh_q[6:0], SDA_I};

  always_comb begin
    ack_d = 1'b0;
    case (ph_q)
      PH_ADDR:  ack_d = (byte_in[7:4] == DEV_TYPE) &&
                        (byte_in[3:0] == strap_q);
      PH_INSTR: ack_d = op_valid(byte_in[7:OPC_LSB]);
      PH_DATA:  ack_d = !(opcode_bits_q == OP_WR_NV && wpb_s_q[1]);
      default:  ack_d = 1'b0;
    endcase
  end

  always_ff @(posedge SCL or posedge link_clr_q) begin
    if (link_clr_q) begin
      ph_q  <= PH_ADDR;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      ack_q <= 1'b0;
    end else if (ph_q == PH_STEP || ph_q == PH_IDLE) begin
      bit_q <= 4'h0;
    end else if (bit_q == BIT_ACK) begin
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      case (ph_q)
        PH_ADDR:  ph_q <= ack_q ? PH_INSTR : PH_IDLE;
        PH_INSTR: begin
          if (!ack_q) begin
            ph_q <= PH_IDLE;
          end else if (op_reads(opcode_bits_q)) begin
            ph_q <= PH_READ;
          end else if (op_writes(opcode_bits_q)) begin
            ph_q <= PH_DATA;
          end else if (opcode_bits_q == OP_INCDEC) begin
            ph_q <= PH_STEP;
          end else begin
            ph_q <= PH_IDLE;
          end
        end
        PH_DATA:  ph_q <= ack_q ? PH_DATA : PH_IDLE;
        PH_READ:  ph_q <= SDA_I ? PH_IDLE : PH_READ;
        default:  ph_q <= PH_IDLE;
      endcase
    end else begin
      sh_q  <= byte_in;
      bit_q <= bit_q + 4'h1;
      if (bit_q == BIT_LAST) begin
        ack_q <= ack_d;
      end
    end
  end

  // Latched command words and event toggles survive the frame clear
  always_ff @(posedge SCL or negedge NRST) begin
    if (!NRST) begin
      opcode_bits_q <= 4'h0;
      slot_sel_q    <= 2'h0;
      pot_sel_q     <= 2'h0;
      data_q        <= 8'h00;
      step_up_q     <= 1'b0;
      ins_tog_q     <= 1'b0;
      dat_tog_q     <= 1'b0;
      stp_tog_q     <= 1'b0;
      wpb_s_q       <= 2'h0;
    end else begin
      wpb_s_q <= {wpb_s_q[0], wp_block_q};
      if (ph_q == PH_INSTR && bit_q == BIT_LAST && ack_d) begin
        opcode_bits_q <= byte_in[7:OPC_LSB];
        slot_sel_q    <= byte_in[SLOT_LSB+:2];
        pot_sel_q     <= byte_in[POT_LSB+:2];
        ins_tog_q     <= ~ins_tog_q;
      end
      if (ph_q == PH_DATA && bit_q == BIT_LAST && ack_d) begin
        data_q    <= byte_in;
        dat_tog_q <= ~dat_tog_q;
      end
      if (ph_q == PH_STEP) begin
        step_up_q <= SDA_I;
        stp_tog_q <= ~stp_tog_q;
      end
    end
  end

  // SDA changes only on the falling SCL edge or at the link clear, and only ever pulls low
  always_ff @(negedge SCL or posedge link_clr_q) begin
    if (link_clr_q) begin
      sda_oe_q <= 1'b0;
    end else if (bit_q == BIT_ACK) begin
      sda_oe_q <= ack_q;
    end else if (ph_q == PH_READ) begin
      sda_oe_q <= ~rd_data_q[~bit_q[2:0]];
    end else begin
      sda_oe_q <= 1'b0;
    end
  end

  always_ff @(negedge SCL or negedge NRST) begin
    if (!NRST) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ins_s_q <= 3'h0;
      dat_s_q <= 3'h0;
      stp_s_q <= 3'h0;
    end else begin
      ins_s_q <= {ins_s_q[1:0], ins_tog_q};
      dat_s_q <= {dat_s_q[1:0], dat_tog_q};
      stp_s_q <= {stp_s_q[1:0], stp_tog_q};
    end
  end

  assign ins_ev = ins_s_q[2] ^ ins_s_q[1];
  assign dat_ev = dat_s_q[2] ^ dat_s_q[1];
  assign stp_ev = stp_s_q[2] ^ stp_s_q[1];

  // Memory port follows the sequencer state directly
  assign nvm.addr  = {idx_q, slot_q};
  assign nvm.we    = (seq_q == SQ_PROG);
  assign nvm.wdata = pend_wiper_q ? wiper_position_reg_q[idx_q]
                                  : pend_data_q;

  // Sequencer: boot recall, transfers, reads, programming
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      seq_q   <= SQ_FETCH;
      idx_q   <= 2'h0;
      slot_q  <= SLOT_ZERO;
      gang_q  <= 1'b1;
      to_rd_q <= 1'b0;
      wait_q  <= '0;
      wiper_position_reg_q <= '0;
      rd_data_q <= 8'h00;
    end else begin
      case (seq_q)
        SQ_IDLE: begin
          if (stop_det && pend_q && !wp_block_q) begin
            seq_q  <= SQ_PROG;
            idx_q  <= pend_gang_q ? 2'h0 : pend_pot_q;
            slot_q <= pend_slot_q;
            gang_q <= pend_gang_q;
            wait_q <= '0;
          end else if (ins_ev) begin
            idx_q   <= (opcode_bits_q == OP_GXFR_D2W) ? 2'h0 : pot_sel_q;
            slot_q  <= slot_sel_q;
            gang_q  <= (opcode_bits_q == OP_GXFR_D2W);
            to_rd_q <= (opcode_bits_q == OP_RD_NV);
            case (opcode_bits_q)
              OP_RD_WIP: rd_data_q <= wiper_position_reg_q[pot_sel_q];
              OP_RD_NV, OP_XFR_D2W, OP_GXFR_D2W: seq_q <= SQ_FETCH;
              default: seq_q <= SQ_IDLE;
            endcase
          end else if (dat_ev && opcode_bits_q == OP_WR_WIP) begin
            wiper_position_reg_q[pot_sel_q] <= data_q;
          end else if (stp_ev) begin
            if (step_up_q &&
                wiper_position_reg_q[pot_sel_q] != WIPER_MAX) begin
              wiper_position_reg_q[pot_sel_q] <=
                wiper_position_reg_q[pot_sel_q] + 8'h01;
            end else if (!step_up_q &&
                         wiper_position_reg_q[pot_sel_q] != WIPER_MIN) begin
              wiper_position_reg_q[pot_sel_q] <=
                wiper_position_reg_q[pot_sel_q] - 8'h01;
            end
          end
        end
        SQ_FETCH: seq_q <= SQ_LOAD;
        SQ_LOAD: begin
          if (to_rd_q) begin
            rd_data_q <= nvm.rdata;
          end else begin
            wiper_position_reg_q[idx_q] <= nvm.rdata;
          end
          if (gang_q && idx_q != POT_LAST) begin
            idx_q <= idx_q + 2'h1;
            seq_q <= SQ_FETCH;
          end else begin
            seq_q <= SQ_IDLE;
          end
        end
        SQ_PROG: begin
          wait_q <= wait_q + CW'(1);
          if (gang_q && idx_q != POT_LAST) begin
            idx_q <= idx_q + 2'h1;
          end else begin
            seq_q <= SQ_WAIT;
          end
        end
        SQ_WAIT: begin
          wait_q <= wait_q + CW'(1);
          if (wait_q >= CW'(NV_CYCLES - 1)) begin
            seq_q <= SQ_IDLE;
          end
        end
        default: seq_q <= SQ_IDLE;
      endcase
    end
  end

  // Pending nonvolatile store, armed by the command, fired at STOP
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pend_q       <= 1'b0;
      pend_gang_q  <= 1'b0;
      pend_wiper_q <= 1'b0;
      pend_pot_q   <= 2'h0;
      pend_slot_q  <= 2'h0;
      pend_data_q  <= 8'h00;
    end else if (start_det || stop_det) begin
      pend_q <= 1'b0;
    end else if (seq_q == SQ_IDLE && ins_ev &&
                 (opcode_bits_q == OP_XFR_W2D ||
                  opcode_bits_q == OP_GXFR_W2D)) begin
      pend_q       <= 1'b1;
      pend_gang_q  <= (opcode_bits_q == OP_GXFR_W2D);
      pend_wiper_q <= 1'b1;
      pend_pot_q   <= pot_sel_q;
      pend_slot_q  <= slot_sel_q;
    end else if (seq_q == SQ_IDLE && dat_ev && opcode_bits_q == OP_WR_NV) begin
      pend_q       <= 1'b1;
      pend_gang_q  <= 1'b0;
      pend_wiper_q <= 1'b0;
      pend_pot_q   <= pot_sel_q;
      pend_slot_q  <= slot_sel_q;
      pend_data_q  <= data_q;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
    end
  end

  nv_store #(.DEPTH(16), .AW(4), .DW(8)) u_store (
    .clk   (CLK),
    .rst_n (NRST),
    .bus   (nvm.mem)
  );

  for (genvar p = 0; p < NPOT; p++) begin : g_tap
    tap_decoder #(.W(WW), .N(1 << WW)) u_dec (
      .clk    (CLK),
      .rst_n  (NRST),
      .pos    (wiper_position_reg_q[p]),
      .onehot (TAP_SEL[p])
    );
  end

  assign WIPER_POS = wiper_position_reg_q;
  assign SDA_OE    = sda_oe_q;
  assign SDA_O     = sda_o_q;
  assign NV_BUSY   = busy_q;
endmodule : qpot_serial_slave

//--- qpot_serial_slave_props.sv
// Pin-level assertions of the quad potentiometer serial slave
`timescale 1ns/1ps
module qpot_serial_slave_props
  import qpot_pkg::*;
#(
  parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES,
  parameter int          NPOT      = 4,
  parameter int          WW        = 8
) (
  input wire logic                         CLK,
  input wire logic                         NRST,
  input wire logic                         SCL,
  input wire logic                         SDA_I,
  input wire logic                         SDA_O,
  input wire logic                         SDA_OE,
  input wire logic [3:0]                   ADDR_STRAP_PINS,
  input wire logic                         WP_N,
  input wire logic [NPOT-1:0][WW-1:0]      WIPER_POS,
  input wire logic [NPOT-1:0][(1<<WW)-1:0] TAP_SEL,
  input wire logic                         NV_BUSY
);
  logic        scl_q, sda_q, frame_q, wp_seen_q;
  logic [3:0]  stop_age_q;
  logic [31:0] busy_cnt_q;
  wire         start_w = scl_q & SCL & sda_q & ~SDA_I;
  wire         stop_w  = scl_q & SCL & ~sda_q & SDA_I;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= SCL;
      sda_q <= SDA_I;
    end
  end

  // Protect seen at START or anywhere inside the frame
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      frame_q   <= 1'b0;
      wp_seen_q <= 1'b0;
    end else if (start_w) begin
      frame_q   <= 1'b1;
      wp_seen_q <= ~WP_N;
    end else begin
      frame_q   <= frame_q & ~stop_w;
      wp_seen_q <= wp_seen_q | (frame_q & ~WP_N);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      stop_age_q <= 4'hF;
      busy_cnt_q <= 32'h0;
    end else begin
      stop_age_q <= stop_w ? 4'h0
                  : stop_age_q + {3'h0, stop_age_q != 4'hF};
      busy_cnt_q <= NV_BUSY ? busy_cnt_q + 32'h1 : 32'h0;
    end
  end

  default clocking dcb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_hold;
    SDA_OE [*8];
  endsequence
  sequence s_release;
    !SDA_OE;
  endsequence

  AST_OPEN_DRAIN:
  assert property (SDA_OE |-> !SDA_O)
    else $error("SDA driven high");
  AST_OE_RISE_SCL_LOW:
  assert property ($rose(SDA_OE) |-> !SCL)
    else $error("SDA pulled while SCL high");
  AST_OE_BIT_SPAN:
  assert property ($rose(SDA_OE) |-> s_hold ##[1:700] s_release)
    else $error("SDA pull too short or never released");
  AST_IDLE_QUIET:
  assert property (!frame_q |-> !SDA_OE)
    else $error("SDA pulled outside a frame");
  AST_BUSY_QUIET:
  assert property (NV_BUSY |-> !SDA_OE)
    else $error("bus answered while programming");
  AST_BUSY_AFTER_STOP:
  assert property ($rose(NV_BUSY) |-> stop_age_q <= 4'hA)
    else $error("programming started without a STOP");
  AST_BUSY_LEN:
  assert property ($fell(NV_BUSY) |-> busy_cnt_q >= NV_CYCLES - 1
                   && busy_cnt_q <= NV_CYCLES + 1)
    else $error("programming time wrong");
  AST_WP_BLOCKS:
  assert property ($rose(NV_BUSY) |-> !wp_seen_q)
    else $error("programming under write protect");
  for (genvar p = 0; p < NPOT; p++) begin : g_tap
    AST_TAP_ONEHOT:
    assert property (1'b1 |=> TAP_SEL[p] ==
      ({{((1<<WW)-1){1'b0}}, 1'b1} << $past(WIPER_POS[p])))
      else $error("tap select does not follow wiper");
  end
endmodule : qpot_serial_slave_props

bind qpot_serial_slave qpot_serial_slave_props #(
  .NV_CYCLES(NV_CYCLES), .NPOT(NPOT), .WW(WW)
) u_props (
  .CLK(CLK), .NRST(NRST), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .ADDR_STRAP_PINS(ADDR_STRAP_PINS), .WP_N(WP_N),
  .WIPER_POS(WIPER_POS), .TAP_SEL(TAP_SEL), .NV_BUSY(NV_BUSY)
);

//--- qpot_bus_master.sv
// Two-wire bus master model: drives SCL, pulls SDA low
`timescale 1ns/1ps
module qpot_bus_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int TQ = 600;
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // SDA only moves while SCL is low
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #TQ;
    scl = 1'b1;
    #(TQ/2);
    s = sda;
    #(TQ/2);
    scl = 1'b0;
    #TQ;
  endtask : bit_io
  task automatic start;
    sda_low = 1'b0;
    #TQ;
    scl = 1'b1;
    #TQ;
    sda_low = 1'b1;
    #TQ;
    scl = 1'b0;
    #TQ;
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    #TQ;
    scl = 1'b1;
    #TQ;
    sda_low = 1'b0;
    #(2*TQ);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic mack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, s);
  endtask : rbyte
endmodule : qpot_bus_master

//--- quad_pot_two_wire_slave_tb_top.sv
// Self-checking bench of the quad potentiometer serial slave
`timescale 1ns/1ps
module quad_pot_two_wire_slave_tb_top;
  import qpot_pkg::*;
  localparam int unsigned NVC = 1000;
  logic              clk, nrst, wp_n, scl, m_low, sda_o, sda_oe, busy, s;
  logic [3:0]        strap, sp;
  logic [3:0][7:0]   wpos;
  logic [3:0][255:0] tap;
  logic [7:0]        rnd_q, ev;
  logic [7:0]        es[16];
  logic [2:0]        a;
  int                fails, n_checks;
  // Pull-up on the wire
  wire               sda_w = ~((sda_oe & ~sda_o) | m_low);

  qpot_serial_slave #(.NV_CYCLES(NVC)) u_dut (
    .CLK(clk), .NRST(nrst), .SCL(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .ADDR_STRAP_PINS(strap), .WP_N(wp_n),
    .WIPER_POS(wpos), .TAP_SEL(tap), .NV_BUSY(busy));
  qpot_bus_master u_mst (.scl(scl), .sda_low(m_low), .sda(sda_w));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  function automatic logic [7:0] step(input logic [7:0] w, input logic up);
    if (up) return (w == WIPER_MAX) ? w : w + 8'h01;
    return (w == WIPER_MIN) ? w : w - 8'h01;
  endfunction : step

  task automatic results;
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t byte %h want %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %0t flag %b want %b", $time, g, e);
    end
  endtask : chk1
  task automatic setwp(input logic v);
    @(posedge clk);
    #2 wp_n = v;
  endtask : setwp
  // Step mode leaves the frame open for the caller
  task automatic cmd(input logic [7:0] ins, input logic dat,
                     input logic [7:0] d);
    u_mst.start();
    u_mst.wbyte({DEV_TYPE, strap}, a[2]);
    u_mst.wbyte(ins, a[1]);
    a[0] = 1'b0;
    if (dat) u_mst.wbyte(d, a[0]);
    if (ins[7:4] != 4'h2) u_mst.stop();
  endtask : cmd
  task automatic poll;
    for (int i = 0; i < 20; i++) begin
      u_mst.start();
      u_mst.wbyte({DEV_TYPE, strap}, s);
      u_mst.stop();
      if (i == 0) chk1(s, 1'b0);
      if (s) break;
    end
    if (!s) fails++;
    if (!s) results();
    chk1(busy, 1'b0);
  endtask : poll
  task automatic rd(input logic [7:0] ins, input logic [7:0] e);
    logic [7:0] d1, d2;
    u_mst.start();
    u_mst.wbyte({DEV_TYPE, strap}, s);
    u_mst.wbyte(ins, s);
    u_mst.rbyte(d1, 1'b1);
    u_mst.rbyte(d2, 1'b0);
    u_mst.stop();
    chk8(d1, e);
    chk8(d2, e);
  endtask : rd
  task automatic wslot(input logic [3:0] k, input logic [7:0] v);
    cmd({4'hC, k}, 1'b1, v);
    chk1(a[0], wp_n);
    chk1(busy, wp_n);
    if (wp_n) es[k] = v;
    if (wp_n) poll();
  endtask : wslot

  initial begin
    #2_450_000;
    fails++;
    results();
  end

  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    rnd_q = lfsr(8'h34);
    strap = rnd_q[3:0];
    fails = 0;
    n_checks = 0;
    for (int k = 0; k < 16; k++) es[k] = NV_RESET_VAL;
    repeat (3) @(posedge clk);
    #2 nrst = 1'b1;
    repeat (20) @(posedge clk);
    for (int p = 0; p < 4; p++) chk8(wpos[p], NV_RESET_VAL);
    chk1(tap[3][NV_RESET_VAL], 1'b1);
    for (int p = 0; p < 4; p++) begin
      rnd_q = lfsr(rnd_q);
      cmd({4'hA, 2'h0, p[1:0]}, 1'b1, rnd_q);
      chk1(&a, 1'b1);
      chk8(wpos[p], rnd_q);
      rd({4'h9, 2'h0, p[1:0]}, rnd_q);
    end
    for (int k = 0; k < 4; k++) begin
      u_mst.start();
      u_mst.wbyte({DEV_TYPE, strap ^ (4'h1 << k)}, s);
      u_mst.stop();
      chk1(s, 1'b0);
    end
    cmd(8'h30, 1'b0, 8'h00);
    chk8({5'h00, a}, 8'h04);
    for (int k = 0; k < 4; k++) begin
      rnd_q = lfsr(rnd_q);
      sp = {k[1:0], rnd_q[1:0]};
      wslot(sp, rnd_q);
      rd({4'hB, sp}, es[sp]);
    end
    cmd({4'hD, sp}, 1'b0, 8'h00);
    chk8(wpos[sp[1:0]], es[sp]);
    cmd({4'hE, 2'h1, sp[1:0]}, 1'b0, 8'h00);
    chk1(busy, 1'b1);
    es[{2'h1, sp[1:0]}] = es[sp];
    poll();
    rd({4'hB, 2'h1, sp[1:0]}, es[sp]);
    cmd({4'h1, 4'h0}, 1'b0, 8'h00);
    for (int p = 0; p < 4; p++) chk8(wpos[p], es[p]);
    cmd({4'h8, 4'hC}, 1'b0, 8'h00);
    for (int p = 0; p < 4; p++) es[{2'h3, p[1:0]}] = es[p];
    poll();
    rd(8'hBE, es[14]);
    setwp(1'b0);
    wslot(4'h6, 8'h5A);
    rd(8'hB6, es[6]);
    setwp(1'b1);
    fork
      cmd(8'hC9, 1'b1, 8'h3C);
      begin
        #5000;
        setwp(1'b0);
      end
    join
    chk1(a[0], 1'b0);
    chk1(busy, 1'b0);
    setwp(1'b1);
    cmd(8'hC7, 1'b1, 8'hA5);
    es[7] = 8'hA5;
    setwp(1'b0);
    poll();
    setwp(1'b1);
    rd(8'hB7, es[7]);
    rd(8'hB9, es[9]);
    ev = 8'hFE;
    cmd(8'hA1, 1'b1, ev);
    cmd(8'h21, 1'b0, 8'h00);
    for (int k = 0; k < 3; k++) begin
      u_mst.bit_io(1'b1, s);
      ev = step(ev, 1'b1);
    end
    chk8(wpos[1], ev);
    for (int k = 0; k < 2; k++) begin
      u_mst.bit_io(1'b0, s);
      ev = step(ev, 1'b0);
    end
    chk8(wpos[1], ev);
    u_mst.stop();
    results();
  end
endmodule : quad_pot_two_wire_slave_tb_top
